// ### logic/slot_field_encrypt_mask.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
module slot_field_encrypt_mask (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      in_valid,
    output logic                           in_ready,
    input  slot_field_pkg::field_in_t      in_field,
    input  wire logic                      kss_valid,
    output logic                           kss_ready,
    input  wire logic [`KSS_BITS-1:0]      key_stream_segment,
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output slot_field_pkg::field_out_t     out_field,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [`ADDR_BITS-1:0]     s_axi_awaddr,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [`ADDR_BITS-1:0]     s_axi_araddr,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp
);

    slot_field_pkg::state_t        state;
    slot_field_pkg::field_in_t     fld_q;
    logic                          use_key_q;
    logic [`KSS_BITS-1:0]          kss_q;
    slot_field_pkg::tail_type_t    tail_kind;
    slot_field_pkg::payload_kind_t pay_kind;
    logic                          tail_ctrl;
    logic                          protected_fmt;
    slot_field_pkg::slot_bits_t    mask;
    slot_field_pkg::slot_bits_t    eff_mask;
    slot_field_pkg::slot_bits_t    seal_in;
    slot_field_pkg::slot_bits_t    sealed;
    logic                          htc_bad;
    logic [`SUB_COUNT-1:0]         sub_bad;
    logic                          x_bad;
    slot_field_pkg::field_out_t    next_out;

    logic [31:0]                   ctrl;
    logic [31:0]                   fields_done;
    logic [31:0]                   segments_used;
    logic [2:0]                    last_tail;
    logic [1:0]                    last_pay;
    logic [5:0]                    last_errs;
    logic                          last_skipped;
    logic [31:0]                   status;

    logic                          aw_have;
    logic                          w_have;
    logic [`ADDR_BITS-1:0]         awaddr_q;
    logic [31:0]                   wdata_q;
    logic [3:0]                    wstrb_q;
    logic                          wr_fire;

    // Register select: 0 none, 1 ctrl, 2 status, 3 fields, 4 segments
    function automatic logic [2:0] reg_sel(input logic [`ADDR_BITS-1:0] a);
        logic [2:0] s;
        s = 3'h0;
        unique case (a)
            `REG_CTRL:     s = 3'h1;
            `REG_STATUS:   s = 3'h2;
            `REG_FIELDS:   s = 3'h3;
            `REG_SEGMENTS: s = 3'h4;
            default:       s = 3'h0;
        endcase
        return s;
    endfunction : reg_sel

    // Header codes pick tail type and payload format
    always_comb begin
        tail_kind     = slot_field_pkg::tail_type_t'(fld_q.bits[`HDR_TAIL_LSB +: 3]); // see R4
        pay_kind      = slot_field_pkg::payload_kind_t'(fld_q.bits[`HDR_PAY_LSB +: 2]); // see R10
        tail_ctrl     = tail_kind == slot_field_pkg::tail_control;
        protected_fmt = pay_kind != slot_field_pkg::pay_plain_user; // see R6 see R7 see R8
    end

    ks_mask_map u_mask (
        .key_stream_segment           (kss_q),
        .tail_ctrl     (tail_ctrl),
        .protected_fmt (protected_fmt),
        .mask          (mask)
    );

    // Transmit seals encrypted bits; receive checks the bits as received
    always_comb begin
        eff_mask = use_key_q ? mask : '0; // see R20
        seal_in  = fld_q.receive ? fld_q.bits : (fld_q.bits ^ eff_mask); // see R19
    end

    check_seal u_seal (
        .bits          (seal_in),
        .protected_fmt (protected_fmt),
        .sealed        (sealed),
        .htc_bad       (htc_bad),
        .sub_bad       (sub_bad),
        .x_bad         (x_bad)
    );

    always_comb begin
        next_out = '0;
        if (!fld_q.full_slot) begin
            next_out.bits = fld_q.bits; // see R15
        end else if (fld_q.receive) begin
            next_out.bits    = fld_q.bits ^ eff_mask;
            next_out.htc_bad = htc_bad;
            next_out.sub_bad = sub_bad;
            next_out.x_bad   = x_bad;
        end else begin
            next_out.bits = sealed; // see R1 see R2
        end
        next_out.encrypted = use_key_q;
    end

    // Field flow: take, fetch segment if encrypting, compute, hand out
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state     <= slot_field_pkg::st_idle;
            in_ready  <= 1'b1;
            kss_ready <= 1'b0;
            out_valid <= 1'b0;
            out_field <= '0;
        end else begin
            unique case (state)
                slot_field_pkg::st_idle: begin
                    if (in_valid && in_ready) begin
                        in_ready <= 1'b0;
                        if (ctrl[`CTRL_ENCRYPT] && in_field.full_slot) begin
                            kss_ready <= 1'b1; // see R21
                            state     <= slot_field_pkg::st_key;
                        end else begin
                            state <= slot_field_pkg::st_run; // see R20
                        end
                    end
                end
                slot_field_pkg::st_key: begin
                    if (kss_valid) begin
                        kss_ready <= 1'b0;
                        state     <= slot_field_pkg::st_run;
                    end
                end
                slot_field_pkg::st_run: begin
                    out_field <= next_out;
                    out_valid <= 1'b1;
                    state     <= slot_field_pkg::st_out;
                end
                slot_field_pkg::st_out: begin
                    if (out_ready) begin
                        out_valid <= 1'b0;
                        in_ready  <= 1'b1;
                        state     <= slot_field_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    // Field and segment capture
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fld_q     <= '0;
            use_key_q <= 1'b0;
            kss_q     <= '0;
        end else begin
            if (in_valid && in_ready) begin
                fld_q     <= in_field;
                use_key_q <= ctrl[`CTRL_ENCRYPT] && in_field.full_slot;
            end
            if (kss_valid && kss_ready) begin
                kss_q <= key_stream_segment;
            end
        end
    end

    // Observation of the last field
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_tail    <= '0;
            last_pay     <= '0;
            last_errs    <= '0;
            last_skipped <= 1'b0;
        end else if (state == slot_field_pkg::st_run) begin
            last_tail    <= tail_kind;
            last_pay     <= pay_kind;
            last_errs    <= {next_out.htc_bad, next_out.sub_bad, next_out.x_bad};
            last_skipped <= ~fld_q.full_slot;
        end
    end

    assign wr_fire = aw_have && w_have && !s_axi_bvalid;

    always_comb begin
        status = '0;
        status[0]     = state != slot_field_pkg::st_idle;
        status[3:1]   = last_tail;
        status[5:4]   = last_pay;
        status[11:6]  = last_errs;
        status[12]    = last_skipped;
        status[13]    = ctrl[`CTRL_ENCRYPT];
    end

    // Software registers; a write to a counter clears it, a count in the same cycle wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl          <= `CTRL_RESET;
            fields_done   <= '0;
            segments_used <= '0;
        end else begin
            if (wr_fire && reg_sel(awaddr_q) == 3'h1 && wstrb_q[0]) begin
                ctrl[`CTRL_ENCRYPT] <= wdata_q[`CTRL_ENCRYPT];
            end
            if (wr_fire && reg_sel(awaddr_q) == 3'h3) begin
                fields_done <= '0;
            end
            if (wr_fire && reg_sel(awaddr_q) == 3'h4) begin
                segments_used <= '0;
            end
            if (state == slot_field_pkg::st_run) begin
                fields_done <= fields_done + 32'h0000_0001;
            end
            if (kss_valid && kss_ready) begin
                segments_used <= segments_used + 32'h0000_0001;
            end
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have       <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have       <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (reg_sel(awaddr_q) == 3'h0 || reg_sel(awaddr_q) == 3'h2)
                                ? 2'h2 : 2'h0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                unique case (reg_sel(s_axi_araddr))
                    3'h1:    s_axi_rdata <= ctrl;
                    3'h2:    s_axi_rdata <= status;
                    3'h3:    s_axi_rdata <= fields_done;
                    3'h4:    s_axi_rdata <= segments_used;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : slot_field_encrypt_mask

// ### logic/slot_field_regs.svh
// Operation
// R1: Each full slot field is 388 bits: 64-bit control part, 324-bit payload part.
// R2: Control part is 8-bit header, 40-bit tail, 16-bit header-tail check, in order.
// R3: Header-tail check is a CRC over header and tail together.
// R4: Tail is one of five types, chosen by a code in the header.
// R5: Payload is 320 data bits then a 4-bit data check CRC over them.
// R6: Two payload kinds: error-protected and user.
// R7: User kind with unprotected channel treats all 320 data bits as data.
// R8: Error-protected kind and protected user kind use protected format, 64 redundancy bits.
// R9: Protected format: each subblock carries a 16-bit CRC over its own data.
// R10: Protected or unprotected format is decided from a header code.
// R11: Encrypt mode never encrypts the header bits.
// R12: Encrypt mode encrypts the tail only when it has the control type.
// R13: Encrypt mode never encrypts the header-tail check.
// R14: Encrypt mode never encrypts the 4-bit data check.
// R15: Layout and encryption apply to full slot fields only.
// R16: Segment bits 0-39 go onto tail bits 8-47 for control tails, else dropped.
// R17: Unprotected format: segment bits 40-359 go onto data bits 0-319.
// R18: Protected format: segment bits per 64-bit subblock, 16-bit gaps unused.
// R19: All checks are computed over encrypted bits, on transmit and receive.
// R20: Clear mode passes fields unmodified and consumes no key stream; the code still recomputes the checks of full slot transmit fields.
// R21: Supplier presents one 360-bit segment per field before it is processed.
`ifndef SLOT_FIELD_REGS_SVH
`define SLOT_FIELD_REGS_SVH

`define FIELD_BITS     388
`define TAIL_LSB       8
`define TAIL_BITS      40
`define HTC_LSB        48
`define HTC_BITS       16
`define DATA_LSB       64
`define DATA_BITS      320
`define XCHK_LSB       384
`define SUB_PITCH      80
`define SUB_BITS       64
`define SUB_COUNT      4
`define KSS_BITS       360
`define KSS_DATA_OFS   40

`define HDR_TAIL_LSB   0
`define HDR_PAY_LSB    3

`define CRC16_POLY     16'h0589
`define CRC4_POLY      4'h3

`define ADDR_BITS      8
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_FIELDS     8'h08
`define REG_SEGMENTS   8'h0c
`define CTRL_RESET     32'h0000_0000
`define CTRL_ENCRYPT   0

`endif

// ### logic/slot_field_pkg.sv
`include "slot_field_regs.svh"

package slot_field_pkg;

    typedef logic [`FIELD_BITS-1:0] slot_bits_t;

    typedef enum logic [2:0] {
        tail_paging   = 3'b000,
        tail_ident    = 3'b001,
        tail_sysinfo  = 3'b010,
        tail_mac_mode = 3'b011,
        tail_control  = 3'b100
    } tail_type_t;

    typedef enum logic [1:0] {
        pay_error_protected = 2'b00,
        pay_plain_user      = 2'b01,
        pay_protected_user  = 2'b10,
        pay_reserved        = 2'b11
    } payload_kind_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_key  = 2'b01,
        st_run  = 2'b10,
        st_out  = 2'b11
    } state_t;

    typedef struct packed {
        logic       receive;
        logic       full_slot;
        slot_bits_t bits;
    } field_in_t;

    typedef struct packed {
        slot_bits_t bits;
        logic       htc_bad;
        logic [3:0] sub_bad;
        logic       x_bad;
        logic       encrypted;
    } field_out_t;

endpackage : slot_field_pkg

// ### logic/ks_mask_map.sv
module ks_mask_map (
    input  wire logic [`KSS_BITS-1:0]      key_stream_segment,
    input  wire logic                      tail_ctrl,
    input  wire logic                      protected_fmt,
    output slot_field_pkg::slot_bits_t     mask
);

    always_comb begin
        mask = '0;
        for (int i = 0; i < `TAIL_BITS; i++) begin
            mask[`TAIL_LSB + i] = tail_ctrl & key_stream_segment[i]; // see R11 see R12 see R16
        end
        for (int i = 0; i < `DATA_BITS; i++) begin
            // Gaps at subblock checks stay clear in protected format
            mask[`DATA_LSB + i] = key_stream_segment[`KSS_DATA_OFS + i] &
                (~protected_fmt | ((i % `SUB_PITCH) < `SUB_BITS)); // see R17 see R18 see R13 see R14
        end
    end

endmodule : ks_mask_map

// ### logic/check_seal.sv
module check_seal (
    input  slot_field_pkg::slot_bits_t     bits,
    input  wire logic                      protected_fmt,
    output slot_field_pkg::slot_bits_t     sealed,
    output logic                           htc_bad,
    output logic [`SUB_COUNT-1:0]          sub_bad,
    output logic                           x_bad
);

    function automatic logic [15:0] crc16_calc(input logic [63:0] d, input int unsigned n);
        logic [15:0] c;
        logic        fb;
        c = '0;
        for (int i = 0; i < 64; i++) begin
            if (i < n) begin
                fb = c[15] ^ d[i];
                c  = {c[14:0], 1'b0};
                if (fb) begin
                    c = c ^ `CRC16_POLY;
                end
            end
        end
        return c;
    endfunction : crc16_calc

    function automatic logic [3:0] crc4_calc(input logic [`DATA_BITS-1:0] d);
        logic [3:0] c;
        logic       fb;
        c = '0;
        for (int i = 0; i < `DATA_BITS; i++) begin
            fb = c[3] ^ d[i];
            c  = {c[2:0], 1'b0};
            if (fb) begin
                c = c ^ `CRC4_POLY;
            end
        end
        return c;
    endfunction : crc4_calc

    always_comb begin
        sealed = bits;
        sealed[`HTC_LSB +: `HTC_BITS] = crc16_calc({16'h0000, bits[`HTC_LSB-1:0]}, 48); // see R3
        sub_bad = '0;
        for (int j = 0; j < `SUB_COUNT; j++) begin
            if (protected_fmt) begin
                sealed[`DATA_LSB + j*`SUB_PITCH + `SUB_BITS +: 16] =
                    crc16_calc(bits[`DATA_LSB + j*`SUB_PITCH +: `SUB_BITS], 64); // see R9
                sub_bad[j] = sealed[`DATA_LSB + j*`SUB_PITCH + `SUB_BITS +: 16] !=
                             bits[`DATA_LSB + j*`SUB_PITCH + `SUB_BITS +: 16];
            end
        end
        sealed[`XCHK_LSB +: 4] = crc4_calc(sealed[`DATA_LSB +: `DATA_BITS]); // see R5
        htc_bad = sealed[`HTC_LSB +: `HTC_BITS] != bits[`HTC_LSB +: `HTC_BITS];
        x_bad   = sealed[`XCHK_LSB +: 4] != bits[`XCHK_LSB +: 4];
    end

endmodule : check_seal

// ### verification/slot_field_encrypt_mask_monitor.sv
`include "slot_field_regs.svh"
module slot_field_encrypt_mask_monitor (
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  in_valid,
    input wire logic                  in_ready,
    input slot_field_pkg::field_in_t  in_field,
    input wire logic                  kss_valid,
    input wire logic                  kss_ready,
    input wire logic [`KSS_BITS-1:0]  key_stream_segment,
    input wire logic                  out_valid,
    input wire logic                  out_ready,
    input slot_field_pkg::field_out_t out_field
);
    timeunit 1ns;
    timeprecision 1ps;
    slot_field_pkg::field_in_t  held;
    slot_field_pkg::slot_bits_t ob;
    logic [`KSS_BITS-1:0]       seg;
    logic                       rx;
    assign ob = out_field.bits;
    assign rx = held.receive;
    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            held <= in_field;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (kss_valid && kss_ready) begin
            seg <= key_stream_segment;
        end
    end
    function automatic logic [63:0] gaps(input logic [387:0] b);
        return {b[143:128], b[223:208], b[303:288], b[383:368]};
    endfunction : gaps
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence short_take;
        in_valid && in_ready && !in_field.full_slot;
    endsequence
    sequence late_result;
        (!kss_ready && !out_valid) ##1 (!kss_ready && out_valid);
    endsequence
    a_short_no_key: assert property (short_take |=> late_result)
        else $error("short field mistimed");
    a_key_result: assert property (kss_valid && kss_ready |=> !out_valid ##1 out_valid)
        else $error("late result");
    a_key_wait: assert property (kss_ready && !kss_valid |=> kss_ready && !out_valid)
        else $error("early result");
    a_header_kept: assert property (out_valid |-> ob[7:0] == held.bits[7:0])
        else $error("header altered");
    a_tail_plain: assert property (out_valid && held.bits[2:0] != 3'b100
        |-> ob[47:8] == held.bits[47:8]) else $error("plain tail altered");
    a_tail_masked: assert property (out_valid && out_field.encrypted && held.bits[2:0] == 3'b100
        |-> ob[47:8] == (held.bits[47:8] ^ seg[39:0])) else $error("tail mask wrong");
    a_rx_checks: assert property (out_valid && rx |-> ob[63:48] == held.bits[63:48]
        && ob[387:384] == held.bits[387:384]) else $error("rx checks altered");
    a_gap_kept: assert property (out_valid && rx && held.bits[4:3] != 2'b01
        |-> gaps(ob) == gaps(held.bits)) else $error("gap masked");
    a_plain_data: assert property (out_valid && rx && out_field.encrypted && held.bits[4:3] == 2'b01
        |-> ob[383:64] == (held.bits[383:64] ^ seg[359:40])) else $error("data mask wrong");
    a_clear_pass: assert property (out_valid && (!held.full_slot || rx && !out_field.encrypted)
        |-> ob == held.bits) else $error("clear field altered");
endmodule : slot_field_encrypt_mask_monitor

// ### verification/key_stream_source.sv
module key_stream_source (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         kss_ready,
    input  wire logic [1:0]   lag,
    output logic              kss_valid,
    output logic [359:0]      key_stream_segment
);
    timeunit 1ns;
    timeprecision 1ps;
    int           seed = 54;
    int           cnt = 0;
    logic [383:0] nxt;
    // Segment on request after a lag, held until taken; idle bits toggle
    always @(posedge ref_clk) begin
        if (reset) begin
            kss_valid <= 1'b0;
            cnt <= 0;
        end else if (kss_valid) begin
            if (kss_ready) begin
                kss_valid <= 1'b0;
                key_stream_segment <= ~key_stream_segment;
            end
        end else if (kss_ready && cnt >= lag) begin
            for (int i = 0; i < 12; i++) nxt[i*32 +: 32] = $random(seed);
            kss_valid <= 1'b1;
            key_stream_segment <= nxt[359:0];
            cnt <= 0;
        end else begin
            cnt <= kss_ready ? cnt + 1 : 0;
            key_stream_segment <= ~key_stream_segment;
        end
    end
endmodule : key_stream_source

// ### verification/slot_field_encrypt_mask_tb.sv
`include "slot_field_regs.svh"
module slot_field_encrypt_mask_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef slot_field_pkg::slot_bits_t bits_t;
    logic                       ref_clk, reset, in_valid, in_ready, kss_valid, kss_ready;
    logic                       out_valid, out_ready;
    logic [`KSS_BITS-1:0]       key_stream_segment, seg;
    slot_field_pkg::field_in_t  in_field;
    slot_field_pkg::field_out_t out_field;
    logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                       s_axi_rvalid, s_axi_rready;
    logic [`ADDR_BITS-1:0]      s_axi_awaddr, s_axi_araddr;
    logic [31:0]                s_axi_wdata, s_axi_rdata;
    logic [3:0]                 s_axi_wstrb;
    logic [1:0]                 s_axi_bresp, s_axi_rresp, lag;
    int                         seed = 54, n_errors = 0, checked = 0, n_seg = 0, n_seg_exp = 0;

    slot_field_encrypt_mask dut_u (.*);
    key_stream_source       ks_u (.*);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
    always @(posedge ref_clk) begin
        if (kss_valid && kss_ready) begin
            seg <= key_stream_segment;
            n_seg++;
        end
    end

    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [399:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        for (int n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (!s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid === 1'b1) break;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        check({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    endtask : axi_wr

    task automatic axi_rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (!s_axi_arvalid && s_axi_rvalid === 1'b1) break;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        check({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, ed});
    endtask : axi_rd

    function automatic logic [15:0] crc(input bits_t b, input int lo, n, w);
        logic [15:0] c, p;
        c = '0;
        p = w == 16 ? `CRC16_POLY : {12'h000, `CRC4_POLY};
        for (int i = lo; i < lo + n; i++)
            c = (c << 1) ^ ((c[w-1] ^ b[i]) ? p : '0);
        return c;
    endfunction : crc

    function automatic bits_t seal(input bits_t b);
        b[63:48] = crc(b, 0, 48, 16);
        for (int j = 0; j < 4; j++)
            if (b[4:3] != 2'b01) b[128 + 80*j +: 16] = crc(b, 64 + 80*j, 64, 16);
        b[387:384] = 4'(crc(b, 64, 320, 4));
        return b;
    endfunction : seal

    function automatic bits_t mask(input bits_t b);
        bits_t m;
        m = '0;
        if (b[2:0] == 3'b100) m[47:8] = seg[39:0];
        for (int i = 0; i < 320; i++)
            if (b[4:3] == 2'b01 || i % 80 < 64) m[64 + i] = seg[40 + i];
        return m;
    endfunction : mask

    function automatic slot_field_pkg::field_out_t expect_out(input slot_field_pkg::field_in_t f,
        logic enc);
        slot_field_pkg::field_out_t o;
        bits_t s;
        o = '0;
        o.encrypted = enc && f.full_slot;
        s = o.encrypted ? mask(f.bits) : '0;
        o.bits = (f.receive || !o.encrypted) ? f.bits ^ s : seal(f.bits ^ s);
        if (f.receive && f.full_slot) begin
            s = seal(f.bits);
            o.htc_bad = s[63:48] != f.bits[63:48];
            for (int j = 0; j < 4; j++)
                o.sub_bad[j] = s[128 + 80*j +: 16] != f.bits[128 + 80*j +: 16];
            o.x_bad = s[387:384] != f.bits[387:384];
        end
        return o;
    endfunction : expect_out

    task automatic run(int i, logic enc);
        slot_field_pkg::field_in_t f;
        bits_t b;
        int r;
        for (int w = 0; w < 13; w++) b = {b[355:0], $random(seed)};
        b[2:0] = 3'(i % 8);
        b[4:3] = 2'((i / 8 + i) % 4);
        r = $random(seed);
        f.receive = r[0];
        f.full_slot = i % 7 != 3;
        f.bits = seal(b);
        if (f.receive && r[2:1] == 2'b01) f.bits[8 + (r >> 8) % 40] ^= 1'b1;
        if (f.receive && r[2:1] == 2'b10) f.bits[64 + (r >> 8) % 320] ^= 1'b1;
        n_seg_exp += int'(enc && f.full_slot);
        lag <= 2'(r >> 4);
        in_field <= f;
        in_valid <= 1'b1;
        @(posedge ref_clk);
        for (int n = 0; n < 50 && in_ready !== 1'b1; n++) @(posedge ref_clk);
        in_valid <= 1'b0;
        for (int n = 0; n < 50 && out_valid !== 1'b1; n++) @(posedge ref_clk);
        repeat (r[4:3]) @(posedge ref_clk);
        check({out_valid, out_field}, {1'b1, expect_out(f, enc)});
        out_ready <= 1'b1;
        @(posedge ref_clk);
        out_ready <= 1'b0;
    endtask : run

    initial begin
        reset = 1'b1;
        {in_valid, out_ready, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {lag, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        in_field = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check({in_ready, kss_ready, out_valid}, 3'b100);
        axi_rd(`REG_CTRL, 32'h0, 2'b00);
        axi_wr(`REG_STATUS, 32'h1, 2'b10);
        axi_wr(8'h10, 32'h1, 2'b10);
        axi_rd(8'h10, 32'h0, 2'b10);
        for (int i = 0; i < 44; i++) begin
            if (i == 8 || i == 40) axi_wr(`REG_CTRL, 32'(i == 8), 2'b00);
            if (i == 8) axi_rd(`REG_CTRL, 32'h1, 2'b00);
            run(i, i >= 8 && i < 40);
        end
        check(n_seg, n_seg_exp);
        axi_rd(`REG_FIELDS, 32'h2c, 2'b00);
        axi_rd(`REG_SEGMENTS, 32'(n_seg_exp), 2'b00);
        axi_wr(`REG_SEGMENTS, 32'h0, 2'b00);
        axi_rd(`REG_SEGMENTS, 32'h0, 2'b00);
        close_out();
    end
endmodule : slot_field_encrypt_mask_tb

bind slot_field_encrypt_mask slot_field_encrypt_mask_monitor chk_u (.*);
